// *** logic/wiper_pkg.sv ***
package wiper_pkg;
  // ----------------------------------------------------------------
  // command field of the instruction byte
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_WIPER   = 3'h0;  // volatile wiper access
  localparam logic [2:0] CMD_NV      = 3'h1;  // nonvolatile copy access
  localparam logic [2:0] CMD_WP      = 3'h2;  // write protect control
  localparam logic [2:0] CMD_NOP     = 3'h4;  // no operation
  localparam logic [2:0] CMD_RESTORE = 3'h5;  // nonvolatile to wiper
  localparam logic [2:0] CMD_STORE   = 3'h6;  // wiper to nonvolatile
  // ----------------------------------------------------------------
  // instruction byte layout and pointer locations
  // ----------------------------------------------------------------
  localparam int          CMD_HI      = 7;     // top of command field
  localparam int          CMD_LO      = 5;     // bottom of command field
  localparam int          PTR_HI      = 4;     // top of pointer field
  localparam logic [4:0]  PTR_TOL_INT = 5'h1E; // sign and integer byte
  localparam logic [4:0]  PTR_TOL_FRC = 5'h1F; // fraction byte
  localparam logic [4:0]  PTR_ZERO    = 5'h00; // ordinary pointer value
  // ----------------------------------------------------------------
  // wiper value width, midscale and addresses
  // ----------------------------------------------------------------
  localparam int          WIPER_W     = 6;     // wiper register width
  localparam logic [5:0]  WIPER_MID   = 6'h20; // midscale power-up value
  localparam int          WP_BIT      = 0;     // protect bit in data byte
  // strap encodings: 0 low, 1 floating, 2 high
  localparam logic [1:0]  STRAP_LOW   = 2'h0;
  localparam logic [1:0]  STRAP_FLOAT = 2'h1;
  localparam logic [1:0]  STRAP_HIGH  = 2'h2;
  // address per strap pair, index hi*3+lo
  localparam logic [6:0]  ADDR_TABLE [0:8] = '{
    7'h18, 7'h29, 7'h4C,
    7'h19, 7'h2A, 7'h4D,
    7'h1A, 7'h2B, 7'h4E
  };
  localparam int          BIT_LAST    = 7;     // last bit index of a byte
  localparam int          ACK_SLOT    = 8;     // ninth clock of each byte
endpackage : wiper_pkg

// *** logic/wiper_bus_if.sv ***
`timescale 1ns/1ps
// two-wire bus joining host and wiper port; open-drain data wire
interface wiper_bus_if;
  logic scl;          // serial clock, driven by host
  logic sda_host_oe;  // host pulls data low while high
  logic sda_dev_oe;   // device pulls data low while high
  logic sda;          // resolved wire level
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport host (output scl, output sda_host_oe, input sda);
  modport dev  (input scl, output sda_dev_oe, input sda);
endinterface : wiper_bus_if

// *** logic/wiper_dev.sv ***
`timescale 1ns/1ps
module wiper_dev #(
  parameter logic [7:0] TOL_INT = 8'h1C,  // factory sign and integer
  parameter logic [7:0] TOL_FRC = 8'h0F   // factory fraction
) (
  // system side
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] addr_strap_lo_i,
  input  wire logic [1:0] addr_strap_hi_i,
  // link side
  input  wire logic       scl_i,
  wiper_bus_if.dev        bus,
  // state seen by the system
  output logic [5:0]      wiper_setting_o,
  output logic [5:0]      stored_wiper_setting_o,
  output logic            write_protect_o
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (TOL_INT[7] !== 1'b0 && TOL_INT[7] !== 1'b1) begin : g_bad
    $error("tolerance byte undefined");
  end
  typedef enum {ST_IDLE, ST_ADDR, ST_INSTR, ST_WDATA, ST_RFIRST, ST_RDATA, ST_SKIP} st_t;
  // ----------------------------------------------------------------
  // sda sampled on scl; start/stop detection on raw data wire
  // ----------------------------------------------------------------
  logic       start_tgl_reg;   // toggles on each start
  logic       stop_tgl_reg;    // toggles on each stop
  // start: data falls while clock high; these flops live on data edge
  always_ff @(negedge bus.sda or negedge rstn_i) begin
    if (!rstn_i) begin
      start_tgl_reg <= 1'b0;
    end else if (scl_i) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end
  always_ff @(posedge bus.sda or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_tgl_reg <= 1'b0;
    end else if (scl_i) begin
      stop_tgl_reg <= ~stop_tgl_reg;
    end
  end
  // ----------------------------------------------------------------
  // strap sample, once after reset release
  // ----------------------------------------------------------------
  logic [6:0] my_addr_reg;     // decoded bus address
  logic       strap_done_reg;  // strap already caught
  logic [3:0] strap_s1_reg;    // pins, first sync stage {hi, lo}
  logic [3:0] strap_s2_reg;    // pins, second sync stage
  logic [1:0] strap_age_reg;   // edges since release, stops at two
  logic [3:0] strap_idx;       // table index
  assign strap_idx = 4'(strap_s2_reg[3:2] * 3 + strap_s2_reg[1:0]);
  // pins are asynchronous: sample only once the sync stages are filled
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      my_addr_reg    <= 7'h00;
      strap_done_reg <= 1'b0;
      strap_s1_reg   <= 4'h0;
      strap_s2_reg   <= 4'h0;
      strap_age_reg  <= 2'h0;
    end else begin
      strap_s1_reg <= {addr_strap_hi_i, addr_strap_lo_i};
      strap_s2_reg <= strap_s1_reg;
      if (!strap_age_reg[1]) begin
        strap_age_reg <= strap_age_reg + 2'h1;
      end else if (!strap_done_reg) begin
        my_addr_reg    <= wiper_pkg::ADDR_TABLE[strap_idx];
        strap_done_reg <= 1'b1;
      end
    end
  end
  // address is static after power-up, so scl logic reads it freely
  // ----------------------------------------------------------------
  // byte engine on scl
  // ----------------------------------------------------------------
  st_t        st_reg;
  logic [3:0] bit_reg;         // bit counter 0..8
  logic [7:0] sh_reg;          // shift register
  logic [7:0] tx_reg;          // byte being sent
  logic [4:0] ptr_reg;         // memory pointer
  logic [2:0] cmd_reg;         // latched command
  logic [5:0] wiper_reg;       // volatile wiper
  logic [5:0] nv_reg;          // nonvolatile copy
  logic       wp_reg;          // write protect
  logic       ack_oe_reg;      // device pulls data
  logic       upd_tgl_reg;     // flips when a byte completes
  logic       st_seen_reg;     // last start toggle handled
  logic       sp_seen_reg;     // last stop toggle handled
  logic       start_now;       // start since last rising edge
  logic       stop_now;        // stop since last rising edge
  logic [7:0] byte_in;         // byte completed on this edge
  logic [7:0] rd_byte;         // byte to present for reads
  assign start_now = start_tgl_reg ^ st_seen_reg;
  assign stop_now  = stop_tgl_reg ^ sp_seen_reg;
  assign byte_in   = {sh_reg[6:0], bus.sda};
  // read source by pointer and command
  assign rd_byte = (ptr_reg == wiper_pkg::PTR_TOL_INT) ? TOL_INT :
                   (ptr_reg == wiper_pkg::PTR_TOL_FRC) ? TOL_FRC :
                   (cmd_reg == wiper_pkg::CMD_NV)      ? {2'h0, nv_reg} :
                                                         {2'h0, wiper_reg};
  // rising scl: sample and advance
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg      <= ST_IDLE;
      bit_reg     <= 4'h0;
      sh_reg      <= 8'h00;
      ptr_reg     <= wiper_pkg::PTR_ZERO;
      cmd_reg     <= wiper_pkg::CMD_WIPER;
      wiper_reg   <= wiper_pkg::WIPER_MID;
      nv_reg      <= wiper_pkg::WIPER_MID;
      wp_reg      <= 1'b0;
      upd_tgl_reg <= 1'b0;
      st_seen_reg <= 1'b0;
      sp_seen_reg <= 1'b0;
    end else begin
      st_seen_reg <= start_tgl_reg;
      sp_seen_reg <= stop_tgl_reg;
      sh_reg      <= byte_in;
      if (start_now) begin
        st_reg  <= ST_ADDR;
        bit_reg <= 4'h1;
      end else if (stop_now) begin
        st_reg  <= ST_IDLE;
        bit_reg <= 4'h0;
      end else if (bit_reg == 4'(wiper_pkg::ACK_SLOT)) begin
        bit_reg  <= 4'h0;
        if (st_reg == ST_RDATA && bus.sda) begin
          st_reg <= ST_SKIP;                   // host_no_ack ends read
        end else if (st_reg == ST_RFIRST) begin
          st_reg <= ST_RDATA;                  // address acked, data follows
        end else if (st_reg == ST_RDATA && ptr_reg == wiper_pkg::PTR_TOL_INT) begin
          ptr_reg <= wiper_pkg::PTR_TOL_FRC;
        end
      end else begin
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'(wiper_pkg::BIT_LAST)) begin
          upd_tgl_reg <= ~upd_tgl_reg;         // registers settle on this edge
          case (st_reg)
            ST_ADDR: begin
              if (byte_in[7:1] != my_addr_reg) begin
                st_reg <= ST_SKIP;
              end else if (byte_in[0]) begin
                st_reg <= ST_RFIRST;
              end else begin
                st_reg <= ST_INSTR;
              end
            end
            ST_INSTR: begin
              cmd_reg <= byte_in[wiper_pkg::CMD_HI:wiper_pkg::CMD_LO];
              ptr_reg <= byte_in[wiper_pkg::PTR_HI:0];
              st_reg  <= ST_WDATA;
              case (byte_in[wiper_pkg::CMD_HI:wiper_pkg::CMD_LO])
                wiper_pkg::CMD_STORE: begin
                  if (!wp_reg) begin
                    nv_reg <= wiper_reg;
                  end
                end
                wiper_pkg::CMD_RESTORE: begin
                  wiper_reg <= nv_reg;
                end
                default: begin
                end
              endcase
            end
            ST_WDATA: begin
              case (cmd_reg)
                wiper_pkg::CMD_WIPER: begin
                  wiper_reg <= byte_in[5:0];
                end
                wiper_pkg::CMD_NV: begin
                  if (!wp_reg) begin
                    nv_reg <= byte_in[5:0];
                  end
                end
                wiper_pkg::CMD_WP: begin
                  wp_reg <= byte_in[wiper_pkg::WP_BIT];
                end
                default: begin
                end
              endcase
            end
            default: begin
            end
          endcase
        end
      end
    end
  end
  // falling scl: drive ack or read bits
  always_ff @(negedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_oe_reg <= 1'b0;
      tx_reg     <= 8'h00;
    end else if (st_reg == ST_IDLE || st_reg == ST_SKIP) begin
      ack_oe_reg <= 1'b0;
    end else if (bit_reg == 4'(wiper_pkg::ACK_SLOT)) begin
      ack_oe_reg <= (st_reg != ST_RDATA);
    end else if (st_reg == ST_RDATA && bit_reg == 4'h0) begin
      // fetch after the host ack edge, so an advanced pointer is seen
      ack_oe_reg <= ~rd_byte[wiper_pkg::BIT_LAST];
      tx_reg     <= {rd_byte[6:0], 1'b1};
    end else if (st_reg == ST_RDATA) begin
      ack_oe_reg <= ~tx_reg[wiper_pkg::BIT_LAST];
      tx_reg     <= {tx_reg[6:0], 1'b1};
    end else begin
      ack_oe_reg <= 1'b0;
    end
  end
  assign bus.sda_dev_oe = ack_oe_reg;
  // ----------------------------------------------------------------
  // state into system clock domain: toggle handshake; the word changes
  // at most once per byte, far slower than the three toggle flops
  // ----------------------------------------------------------------
  logic [2:0]  upd_sync_reg;    // two sync flops, then an edge stage
  logic [12:0] state_reg;       // {protect, stored, wiper} seen here
  logic        upd_seen;        // toggle moved, word is stable
  assign upd_seen = upd_sync_reg[2] ^ upd_sync_reg[1];
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upd_sync_reg <= 3'h0;
      state_reg    <= {1'b0, wiper_pkg::WIPER_MID, wiper_pkg::WIPER_MID};
    end else begin
      upd_sync_reg <= {upd_sync_reg[1:0], upd_tgl_reg};
      if (upd_seen) begin
        state_reg <= {wp_reg, nv_reg, wiper_reg};
      end
    end
  end
  assign wiper_setting_o        = state_reg[5:0];
  assign stored_wiper_setting_o = state_reg[11:6];
  assign write_protect_o        = state_reg[12];
endmodule : wiper_dev

// *** logic/wiper_host.sv ***
`timescale 1ns/1ps
// host end: runs one transaction per request, scl divided from clock_i
module wiper_host #(
  parameter int DIV = 4                  // clock_i cycles per scl quarter period
) (
  // system side
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // request group
  input  wire logic       req_i,         // one-cycle start pulse
  input  wire logic [6:0] addr_i,        // device address
  input  wire logic [7:0] instr_i,       // instruction byte
  input  wire logic       do_instr_i,    // send address+instruction first
  input  wire logic       do_data_i,     // send data byte after instruction
  input  wire logic [7:0] data_i,        // data byte
  input  wire logic [1:0] rd_count_i,    // bytes to read, 0 none
  // link side
  wiper_bus_if.host       bus,
  // answer group
  output logic            busy_o,
  output logic            done_o,        // one-cycle end pulse
  output logic            nak_o,         // device failed to ack
  output logic [15:0]     rd_data_o      // first byte high, second low
);
  if (DIV < 2) begin : g_bad
    $error("DIV must be at least 2");
  end
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} hst_t;
  // ----------------------------------------------------------------
  // frame list: up to 4 bytes, each with a start-before flag
  // ----------------------------------------------------------------
  hst_t        st_reg;
  logic [15:0] cnt_reg;      // quarter-period timer
  logic [1:0]  phase_reg;    // 0 low-set,1 high,
  logic [3:0]  bit_reg;      // 0..8 within byte
  logic [2:0]  byte_reg;     // index into list
  logic [2:0]  nbytes_reg;   // bytes in list
  logic [7:0]  list_reg [0:3];
  logic [3:0]  isrd_reg;     // byte is received
  logic [3:0]  rs_reg;       // repeated start before byte
  logic        scl_reg;
  logic        sda_oe_reg;
  logic        sda_s1_reg;
  logic        sda_s2_reg;   // synchronised data wire
  logic        tick;
  assign tick = (cnt_reg == 16'(DIV - 1));
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= H_IDLE; cnt_reg <= 16'h0000; phase_reg <= 2'h0;
      bit_reg <= 4'h0; byte_reg <= 3'h0; nbytes_reg <= 3'h0;
      for (int i = 0; i < 4; i++) list_reg[i] <= 8'h00;
      isrd_reg <= 4'h0; rs_reg <= 4'h0; scl_reg <= 1'b1; sda_oe_reg <= 1'b0;
      busy_o <= 1'b0; done_o <= 1'b0; nak_o <= 1'b0; rd_data_o <= 16'h0000;
    end else begin
      done_o  <= 1'b0;
      cnt_reg <= tick ? 16'h0000 : cnt_reg + 16'h0001;
      case (st_reg)
        H_IDLE: begin
          if (req_i) begin
            // write part then optional read part after repeated start
            list_reg[0] <= {addr_i, 1'b0};
            list_reg[1] <= instr_i;
            list_reg[2] <= do_data_i ? data_i : {addr_i, 1'b1};
            list_reg[3] <= {addr_i, 1'b1};
            busy_o <= 1'b1; nak_o <= 1'b0; st_reg <= H_START;
            cnt_reg <= 16'h0000; phase_reg <= 2'h0;
            if (!do_instr_i) begin
              list_reg[0] <= {addr_i, 1'b1};
              nbytes_reg <= 3'(1 + rd_count_i);
              isrd_reg <= 4'b0110; rs_reg <= 4'b0000;
            end else if (do_data_i) begin
              nbytes_reg <= 3'h3; isrd_reg <= 4'b0000; rs_reg <= 4'b0000;
            end else if (rd_count_i != 2'h0) begin
              nbytes_reg <= 3'(3 + rd_count_i);  // host_ack between reads
              isrd_reg <= 4'b1000; rs_reg <= 4'b0100;
            end else begin
              nbytes_reg <= 3'h2; isrd_reg <= 4'b0000; rs_reg <= 4'b0000;
            end
            byte_reg <= 3'h0;
          end
        end
        H_START: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b0;            // clock left as it stands
              2'h1: scl_reg <= 1'b1;
              2'h2: sda_oe_reg <= 1'b1;            // data falls, clock high
              default: begin scl_reg <= 1'b0; bit_reg <= 4'h0;
                phase_reg <= 2'h0; st_reg <= H_BIT; end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin                          // clock low: set data
                if (bit_reg == 4'h8) begin
                  // ack slot: host acks read bytes except the last
                  sda_oe_reg <= (byte_reg >= 3'h3 || (isrd_reg[1] && byte_reg != 3'h0))
                                && byte_reg + 3'h1 < nbytes_reg;
                end else if (byte_reg >= 3'h3 || (isrd_reg[1] && byte_reg != 3'h0)) begin
                  sda_oe_reg <= 1'b0;
                end else begin
                  sda_oe_reg <= ~list_reg[byte_reg[1:0]][3'(7 - bit_reg)];
                end
              end
              2'h1: scl_reg <= 1'b1;
              2'h2: begin                          // clock high: sample
                if (bit_reg == 4'h8) begin
                  if ((byte_reg < 3'h3 && !isrd_reg[1]) || byte_reg == 3'h0) begin
                    nak_o <= nak_o | sda_s2_reg;
                  end
                end else if (byte_reg >= 3'h3 || (isrd_reg[1] && byte_reg != 3'h0)) begin
                  rd_data_o <= {rd_data_o[14:0], sda_s2_reg};
                end
              end
              default: begin
                scl_reg <= 1'b0; phase_reg <= 2'h0;
                if (bit_reg != 4'h8) begin
                  bit_reg <= bit_reg + 4'h1;
                end else if (byte_reg + 3'h1 == nbytes_reg) begin
                  st_reg <= H_STOP;
                end else begin
                  bit_reg <= 4'h0; byte_reg <= byte_reg + 3'h1;
                  if (byte_reg < 3'h3 && rs_reg[byte_reg[1:0] + 2'h1]) begin
                    list_reg[2] <= list_reg[3]; st_reg <= H_START;
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;            // hold low under clock
              2'h1: scl_reg <= 1'b1;
              2'h2: sda_oe_reg <= 1'b0;            // data rises: stop
              default: begin busy_o <= 1'b0; done_o <= 1'b1;
                phase_reg <= 2'h0; st_reg <= H_IDLE; end
            endcase
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
  assign bus.scl         = scl_reg;
  assign bus.sda_host_oe = sda_oe_reg;
endmodule : wiper_host

// *** testbench/i2c_wiper_command_port_sva.sv ***
`timescale 1ns/1ps
module i2c_wiper_command_port_sva #(
  parameter logic [6:0] DEV_ADDR = 7'h4C  // strap-decoded address
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rstn_i,
  // bus wires
  input  wire logic scl,
  input  wire logic sda_host_oe,
  input  wire logic sda_dev_oe,
  input  wire logic sda
);
  localparam int REL_MAX = 64;  // release bound, room for a slow divider
  // ----------------------------------------------------------------
  // frame tracker
  // ----------------------------------------------------------------
  logic       scl_q;     // scl one cycle ago
  logic       sda_q;     // sda one cycle ago
  logic       in_frame;  // between start and stop
  logic       mine;      // frame addressed to this device
  logic       rd_frame;  // read direction of last address
  logic [3:0] bit_cnt;   // scl rises in this byte
  logic [3:0] byte_idx;  // bytes since last start
  logic [7:0] shreg;     // bits of this byte
  wire        scl_rise = scl & ~scl_q;
  wire        start_c  = scl & scl_q & sda_q & ~sda;
  wire        stop_c   = scl & scl_q & ~sda_q & sda;
  wire        slot     = scl_rise & in_frame & (bit_cnt == 4'h8);  // ninth rise
  // a repeated start restarts the byte count like a fresh one
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      mine <= 1'b0;
      rd_frame <= 1'b0;
      bit_cnt <= 4'h0;
      byte_idx <= 4'h0;
      shreg <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c) begin
        in_frame <= 1'b1;
        bit_cnt <= 4'h0;
        byte_idx <= 4'h0;
      end else if (stop_c) begin
        in_frame <= 1'b0;
      end else if (slot) begin
        bit_cnt <= 4'h0;
        byte_idx <= byte_idx + 4'h1;
        if (byte_idx == 4'h0) begin
          mine <= (shreg[7:1] == DEV_ADDR);
          rd_frame <= shreg[0];
        end
      end else if (scl_rise && in_frame) begin
        bit_cnt <= bit_cnt + 4'h1;
        shreg <= {shreg[6:0], sda};
      end
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_addr_slot;
    slot && byte_idx == 4'h0;
  endsequence
  sequence s_write_slot;
    slot && byte_idx != 4'h0 && !rd_frame;
  endsequence
  a_addr_match_ack: assert property (s_addr_slot ##0 shreg[7:1] == DEV_ADDR |-> sda_dev_oe)
    else $error("own address not acknowledged");
  a_addr_miss_quiet: assert property (s_addr_slot ##0 shreg[7:1] != DEV_ADDR |-> !sda_dev_oe)
    else $error("foreign address acknowledged");
  a_instr_ack: assert property (s_write_slot ##0 (byte_idx == 4'h1 && mine) |-> sda_dev_oe)
    else $error("instruction byte not acknowledged");
  a_data_byte_ack: assert property (s_write_slot ##0 (byte_idx >= 4'h2 && mine) |-> sda_dev_oe)
    else $error("data byte not acknowledged");
  a_read_slot_free: assert property (slot && byte_idx != 4'h0 && rd_frame |-> !sda_dev_oe)
    else $error("device drove the host acknowledge slot");
  a_ack_release: assert property (s_write_slot |-> ##[1:REL_MAX] !sda_dev_oe)
    else $error("acknowledge not released");
  a_idle_dev_quiet: assert property (!in_frame && !start_c |-> !sda_dev_oe)
    else $error("device drove data outside a frame");
  a_idle_scl_high: assert property (!in_frame |-> scl)
    else $error("clock low outside a frame");
  a_host_slot_free: assert property (s_write_slot |-> !sda_host_oe)
    else $error("host drove the device acknowledge slot");
endmodule : i2c_wiper_command_port_sva

// *** testbench/i2c_wiper_command_port_test.sv ***
`timescale 1ns/1ps
module i2c_wiper_command_port_test;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV = 7'h4C;  // straps: hi low, lo high
  localparam logic [7:0] TI  = 8'h9C;  // negative, 28 percent
  localparam logic [7:0] TF  = 8'h0F;  // fraction byte
  logic        clock_i = 1'b0;
  logic        rstn_i  = 1'b0;
  logic        req     = 1'b0;
  logic [6:0]  addr    = DEV;
  logic [7:0]  instr   = 8'h00;
  logic        do_ins  = 1'b0;
  logic        do_dat  = 1'b0;
  logic [7:0]  data    = 8'h00;
  logic [1:0]  rd_cnt  = 2'h0;
  wire         busy;
  wire         done;
  wire         nak;
  wire  [15:0] rd_data;
  wire  [5:0]  wiper;
  wire  [5:0]  nv;
  wire         wp;
  int          err_total = 0;
  int          comparisons = 0;
  always #10 clock_i = ~clock_i;
  wiper_bus_if bus_if ();
  wiper_host u_wiper_host (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req), .addr_i(addr),
    .instr_i(instr), .do_instr_i(do_ins), .do_data_i(do_dat), .data_i(data),
    .rd_count_i(rd_cnt), .bus(bus_if), .busy_o(busy), .done_o(done), .nak_o(nak),
    .rd_data_o(rd_data));
  wiper_dev #(.TOL_INT(TI), .TOL_FRC(TF)) u_wiper_dev (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr_strap_lo_i(wiper_pkg::STRAP_HIGH), .addr_strap_hi_i(wiper_pkg::STRAP_LOW),
    .scl_i(bus_if.scl), .bus(bus_if), .wiper_setting_o(wiper),
    .stored_wiper_setting_o(nv), .write_protect_o(wp));
  i2c_wiper_command_port_sva #(.DEV_ADDR(DEV)) u_sva (.clock_i(clock_i), .rstn_i(rstn_i),
    .scl(bus_if.scl), .sda_host_oe(bus_if.sda_host_oe), .sda_dev_oe(bus_if.sda_dev_oe),
    .sda(bus_if.sda));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one frame; inputs held until done, bounded wait
  task automatic xfer(input logic [7:0] ins, input logic di, input logic dd,
                      input logic [7:0] d, input logic [1:0] rc, input logic [6:0] a = DEV);
    int n;
    n = 0;
    req <= 1'b1;
    instr <= ins;
    do_ins <= di;
    do_dat <= dd;
    data <= d;
    rd_cnt <= rc;
    addr <= a;
    @(posedge clock_i);
    req <= 1'b0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 5000) begin
      err_total++;
      summarize();
    end
    repeat (4) @(posedge clock_i);  // outputs pass a two-flop sync
  endtask : xfer
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_wiper();
    check("reset wiper", 16'(wiper), 16'h0020);
    check("reset nv", 16'(nv), 16'h0020);
    xfer(8'h00, 1'b1, 1'b1, 8'hE5, 2'h0);
    check("wiper write", 16'(wiper), 16'h0025);
    xfer(8'h00, 1'b1, 1'b0, 8'h00, 2'h1);
    check("wiper read", 16'(rd_data[5:0]), 16'h0025);
    check("read address ack", 16'(nak), 16'h0000);
    xfer(8'h00, 1'b1, 1'b1, 8'hFF, 2'h0);
    xfer(8'h00, 1'b0, 1'b0, 8'h00, 2'h1);
    check("direct read", 16'(rd_data[5:0]), 16'h003F);
  endtask : t_wiper
  task automatic t_nv();
    xfer(8'h20, 1'b1, 1'b1, 8'hDA, 2'h0);
    check("nv write", 16'(nv), 16'h001A);
    xfer(8'h20, 1'b1, 1'b0, 8'h00, 2'h1);
    check("nv read", 16'(rd_data[5:0]), 16'h001A);
    xfer(8'h00, 1'b1, 1'b1, 8'hC7, 2'h0);
    xfer(8'hC0, 1'b1, 1'b0, 8'h00, 2'h0);
    check("store", 16'(nv), 16'h0007);
    xfer(8'h00, 1'b1, 1'b1, 8'h11, 2'h0);
    xfer(8'hA0, 1'b1, 1'b0, 8'h00, 2'h0);
    check("restore", 16'(wiper), 16'h0007);
  endtask : t_nv
  task automatic t_protect();
    xfer(8'h40, 1'b1, 1'b1, 8'h01, 2'h0);
    check("protect on", 16'(wp), 16'h0001);
    xfer(8'h20, 1'b1, 1'b1, 8'h2A, 2'h0);
    check("nv write blocked", 16'(nv), 16'h0007);
    xfer(8'h00, 1'b1, 1'b1, 8'h15, 2'h0);
    xfer(8'hC0, 1'b1, 1'b0, 8'h00, 2'h0);
    check("store blocked", 16'(nv), 16'h0007);
    xfer(8'h40, 1'b1, 1'b1, 8'h00, 2'h0);
    check("protect off", 16'(wp), 16'h0000);
    xfer(8'hC0, 1'b1, 1'b0, 8'h00, 2'h0);
    check("store after unprotect", 16'(nv), 16'h0015);
  endtask : t_protect
  task automatic t_tol_nop_miss();
    xfer(8'h3E, 1'b1, 1'b0, 8'h00, 2'h2);
    check("tolerance pair", rd_data, {TI, TF});
    check("tolerance units", 16'({rd_data[14:8], rd_data[7:0]}), 16'h1C0F);
    xfer(8'h3F, 1'b1, 1'b0, 8'h00, 2'h1);
    check("fraction alone", 16'(rd_data[7:0]), 16'(TF));
    xfer(8'h3E, 1'b1, 1'b0, 8'h00, 2'h1);
    check("sign integer alone", 16'(rd_data[7:0]), 16'(TI));
    xfer(8'h00, 1'b1, 1'b1, 8'h2C, 2'h0);
    xfer(8'h80, 1'b1, 1'b0, 8'h00, 2'h0);
    check("nop ack", 16'(nak), 16'h0000);
    check("nop keeps wiper", 16'(wiper), 16'h002C);
    check("nop keeps nv", 16'(nv), 16'h0015);
    xfer(8'h00, 1'b1, 1'b1, 8'h01, 2'h0, 7'h18);
    check("foreign nak", 16'(nak), 16'h0001);
    check("foreign no write", 16'(wiper), 16'h002C);
  endtask : t_tol_nop_miss
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    t_wiper();
    t_nv();
    t_protect();
    t_tol_nop_miss();
    summarize();
  end
endmodule : i2c_wiper_command_port_test
